//--- logic/cscr_consts.svh
/*
 * Holds the fixed numbers of the core status and configuration register bank:
 * register addresses in direct register space, bit positions, reset values and
 * write masks. Assumes it is included by its bare name from design files.
 */
`ifndef CSCR_CONSTS_SVH
`define CSCR_CONSTS_SVH

// ************************************************************
// register addresses in direct register space
// ************************************************************
`define CSCR_ADDR_STACK_LOW 8'h81
`define CSCR_ADDR_DP_LOW 8'h82
`define CSCR_ADDR_DP_HIGH 8'h83
`define CSCR_ADDR_DP_PAGE 8'h84
`define CSCR_ADDR_POWER_CONTROL 8'h87
`define CSCR_ADDR_CHIP_CONFIG 8'haf
`define CSCR_ADDR_STACK_UPPER 8'hb7
`define CSCR_ADDR_STATUS_WORD 8'hd0

// ************************************************************
// reset values
// ************************************************************
`define CSCR_RESET_STACK_LOW 8'h07
`define CSCR_RESET_STACK_UPPER 3'h0
`define CSCR_RESET_BYTE 8'h00
`define CSCR_RESET_DP_PAGE 8'h00

// ************************************************************
// write masks: a 1 marks a bit that software may change
// ************************************************************
`define CSCR_WMASK_POWER_CONTROL 8'hfe
`define CSCR_WMASK_CHIP_CONFIG 8'h81
`define CSCR_WMASK_STATUS_WORD 8'hfe
`define CSCR_WMASK_STACK_UPPER 8'h07

// ************************************************************
// status word bit positions
// ************************************************************
`define CSCR_SW_CARRY 7
`define CSCR_SW_HALF_CARRY 6
`define CSCR_SW_USER_A 5
`define CSCR_SW_BANK_HIGH 4
`define CSCR_SW_BANK_LOW 3
`define CSCR_SW_ARITH_RANGE 2
`define CSCR_SW_USER_B 1
`define CSCR_SW_PARITY 0

// ************************************************************
// power control and configuration bit positions
// ************************************************************
`define CSCR_PWR_BAUD_DOUBLER 7
`define CSCR_PWR_SERIAL_WAKE 6
`define CSCR_PWR_EXT_IRQ0_WAKE 5
`define CSCR_PWR_LATCH_OFF 4
`define CSCR_PWR_USER_D 3
`define CSCR_PWR_USER_C 2
`define CSCR_PWR_POWER_DOWN 1
`define CSCR_CFG_EXT_STACK 7
`define CSCR_CFG_XDATA_MAP 0

// ************************************************************
// address space limits
// ************************************************************
`define CSCR_INTERNAL_XDATA_TOP 24'h00_07ff

`endif

//--- logic/cscr_core_regs.sv
/*
 * Core register bank: data pointer, extended stack pointer, status word,
 * power control and chip configuration on the direct register port.
 * Assumes CPU requests on clk, one per cycle, with clk running in power-down.
 */
`timescale 1ns/1ps
`include "cscr_consts.svh"

// Notes on behaviour
// R01 - pointer is page, high and low bytes; increment carries into page
// R02 - pointer loads as one 16-bit word or three separate bytes
// R03 - push or call increments the stack pointer before the store
// R04 - reset sets stack pointer to 07H; first stacked byte at 08H
// R05 - upper three stack bits are the low bits of register B7H
// R06 - extended stack off: upper stack register neither written nor read
// R07 - status word holds carry, half carry, user flags, range flag, parity
// R08 - status bits 4 and 3 pick register bank 0 to 3 in binary
// R09 - power bit 7 set doubles the serial baud rate
// R10 - power bit 6 set: serial interrupt ends power-down
// R11 - power bit 5 set: interrupt zero pin ends power-down, level or edge
// R12 - power bit 4 set disables the address latch strobe
// R13 - power bits 3 and 2 are plain flags; unimplemented bits ignore writes
// R14 - writing 1 to power bit 1 enters power-down
// R15 - configuration reads 00H after reset, both extensions off
// R16 - extended stack on: 11-bit pointer rolls 00FFH to 0100H
// R17 - extended stack off: 8-bit pointer wraps FFH to 00H
// R18 - map enable set: internal xdata in the lowest 2 kbytes
// R19 - map enable clear: xdata accesses all go off chip
// R20 - pointer above 0007FFH goes off chip even with mapping on
// R21 - parity bit follows accumulator each cycle, 1 for odd ones
module cscr_core_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    output logic [7:0] sfrReadData,
    output logic sfrReadHit,
    input wire logic dptrIncrement,
    input wire logic dptrLoad16,
    input wire logic [15:0] dptrLoadValue,
    output logic [23:0] dataPointer,
    output logic xdataOnChip,
    input wire logic stackPush,
    input wire logic stackPop,
    output logic [10:0] stackAddress,
    input wire logic flagUpdate,
    input wire logic carryIn,
    input wire logic halfCarryIn,
    input wire logic rangeIn,
    input wire logic [7:0] accumulator,
    output logic [1:0] bankSelect,
    output logic baudDoubler,
    output logic latchStrobeEnable,
    input wire logic spiIrq,
    input wire logic i2cIrq,
    input wire logic extIrq0Pin,
    input wire logic extIrq0TriggerType,
    output logic powerDownActive
);

    cscr_pkg::cscr_bank_state_t state_reg;
    cscr_pkg::cscr_bank_state_t state_next;

    logic extIrq0Wake;
    logic serialWake;
    logic wakeEvent;
    logic extStackOn;
    logic [23:0] pointerNext;

    // ************************************************************
    // helpers
    // ************************************************************

    // merge only the writable bits; unwritable bits keep their value
    function automatic logic [7:0] cscr_masked_write(
        input logic [7:0] oldValue,
        input logic [7:0] newValue,
        input logic [7:0] mask
    );
        cscr_masked_write = (oldValue & ~mask) | (newValue & mask);
    endfunction : cscr_masked_write

    // one step of the stack pointer, up or down, in 8 or 11 bits
    function automatic logic [10:0] cscr_stack_step(
        input logic [10:0] current,
        input logic wide,
        input logic up
    );
        logic [10:0] stepped;
        logic [7:0] lowStep;
        stepped = up ? (current + 11'h001) : (current - 11'h001);
        lowStep = up ? (current[7:0] + 8'h01) : (current[7:0] - 8'h01);
        if (wide) begin
            cscr_stack_step = stepped; // 00FFH rolls into 0100H [R16]
        end else begin
            cscr_stack_step = {current[10:8], lowStep}; // FFH wraps to 00H [R17]
        end
    endfunction : cscr_stack_step

    // ************************************************************
    // wake sources
    // ************************************************************

    // pin passes the two-stage synchroniser inside the detector
    cscr_wake_detect wakeDetect (
        .clk(clk),
        .reset(reset),
        .pinIn(extIrq0Pin),
        .triggerEdge(extIrq0TriggerType),
        .wakeCondition(extIrq0Wake)
    );

    // either serial block may wake, gated by its enable
    assign serialWake = state_reg.powerControl[`CSCR_PWR_SERIAL_WAKE] & (spiIrq | i2cIrq); // [R10]
    assign wakeEvent = serialWake
                     | (state_reg.powerControl[`CSCR_PWR_EXT_IRQ0_WAKE] & extIrq0Wake); // [R11]
    assign extStackOn = state_reg.chipConfig[`CSCR_CFG_EXT_STACK];

    // ************************************************************
    // next state
    // ************************************************************

    // byte writes first, datapath strobes then take precedence
    always_comb begin
        logic [10:0] stackFull;
        logic [10:0] stackStepped;
        stackFull = {state_reg.stackUpper, state_reg.stackLow};
        stackStepped = stackFull;
        pointerNext = 24'h00_0000;
        state_next = state_reg;

        // register writes from the direct register port
        if (sfrWrite) begin
            unique case (sfrAddr)
                `CSCR_ADDR_DP_LOW: state_next.dpLow = sfrWriteData; // [R02]
                `CSCR_ADDR_DP_HIGH: state_next.dpHigh = sfrWriteData; // [R02]
                `CSCR_ADDR_DP_PAGE: state_next.dpPage = sfrWriteData; // [R02]
                `CSCR_ADDR_STACK_LOW: state_next.stackLow = sfrWriteData;
                `CSCR_ADDR_STACK_UPPER: begin
                    // blocked entirely while the extended stack is off
                    if (extStackOn) begin
                        state_next.stackUpper = sfrWriteData[2:0]; // [R05] [R06]
                    end
                end
                `CSCR_ADDR_STATUS_WORD: begin
                    state_next.statusWord = cscr_masked_write(state_reg.statusWord,
                        sfrWriteData, `CSCR_WMASK_STATUS_WORD); // [R07] [R08]
                end
                `CSCR_ADDR_POWER_CONTROL: begin
                    // bit 1 written as 1 enters power-down
                    state_next.powerControl = cscr_masked_write(state_reg.powerControl,
                        sfrWriteData, `CSCR_WMASK_POWER_CONTROL); // [R13] [R14]
                end
                `CSCR_ADDR_CHIP_CONFIG: begin
                    state_next.chipConfig = cscr_masked_write(state_reg.chipConfig,
                        sfrWriteData, `CSCR_WMASK_CHIP_CONFIG); // [R13]
                end
                default: begin
                end
            endcase
        end

        // datapath pointer increment beats any byte write; a 16-bit load beats high and low byte writes only
        if (dptrLoad16) begin
            state_next.dpHigh = dptrLoadValue[15:8]; // [R02]
            state_next.dpLow = dptrLoadValue[7:0]; // [R02]
        end else if (dptrIncrement) begin
            // full 24-bit increment so high byte carry reaches the page byte
            pointerNext = {state_reg.dpPage, state_reg.dpHigh, state_reg.dpLow} + 24'h00_0001;
            state_next.dpPage = pointerNext[23:16]; // [R01]
            state_next.dpHigh = pointerNext[15:8]; // [R01]
            state_next.dpLow = pointerNext[7:0]; // [R01]
        end

        // push steps before the store, pop steps after the read
        if (stackPush ^ stackPop) begin
            stackStepped = cscr_stack_step(stackFull, extStackOn, stackPush); // [R03]
            state_next.stackLow = stackStepped[7:0];
            state_next.stackUpper = stackStepped[10:8]; // [R16]
        end

        // datapath flags win over a software write in the same cycle
        if (flagUpdate) begin
            state_next.statusWord[`CSCR_SW_CARRY] = carryIn; // [R07]
            state_next.statusWord[`CSCR_SW_HALF_CARRY] = halfCarryIn; // [R07]
            state_next.statusWord[`CSCR_SW_ARITH_RANGE] = rangeIn; // [R07]
        end

        // parity tracks the accumulator, one cycle behind it
        state_next.statusWord[`CSCR_SW_PARITY] = ^accumulator; // [R21]

        // a wake in the same cycle as the entering write keeps the part awake
        if (wakeEvent) begin
            state_next.powerControl[`CSCR_PWR_POWER_DOWN] = 1'b0; // [R10] [R11]
        end

        // route decision for the pointer as it will stand next cycle
        state_next.routeInternal = state_next.chipConfig[`CSCR_CFG_XDATA_MAP] // [R18] [R19]
            && ({state_next.dpPage, state_next.dpHigh, state_next.dpLow}
                <= `CSCR_INTERNAL_XDATA_TOP); // [R20]

        // registered read answer, zero and no hit for an unmapped address
        state_next.readData = 8'h00;
        state_next.readHit = 1'b0;
        if (sfrRead) begin
            state_next.readHit = 1'b1;
            unique case (sfrAddr)
                `CSCR_ADDR_DP_LOW: state_next.readData = state_reg.dpLow; // [R02]
                `CSCR_ADDR_DP_HIGH: state_next.readData = state_reg.dpHigh; // [R02]
                `CSCR_ADDR_DP_PAGE: state_next.readData = state_reg.dpPage; // [R02]
                `CSCR_ADDR_STACK_LOW: state_next.readData = state_reg.stackLow;
                `CSCR_ADDR_STACK_UPPER: begin
                    // invisible while the extended stack is off
                    if (extStackOn) begin
                        state_next.readData = {5'h00, state_reg.stackUpper}; // [R05]
                    end else begin
                        state_next.readHit = 1'b0; // [R06]
                    end
                end
                `CSCR_ADDR_STATUS_WORD: state_next.readData = state_reg.statusWord;
                `CSCR_ADDR_POWER_CONTROL: state_next.readData = state_reg.powerControl;
                `CSCR_ADDR_CHIP_CONFIG: state_next.readData = state_reg.chipConfig;
                default: state_next.readHit = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************

    // constants only under reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg.dpPage <= `CSCR_RESET_DP_PAGE;
            state_reg.dpHigh <= `CSCR_RESET_BYTE;
            state_reg.dpLow <= `CSCR_RESET_BYTE;
            state_reg.stackLow <= `CSCR_RESET_STACK_LOW; // [R04]
            state_reg.stackUpper <= `CSCR_RESET_STACK_UPPER;
            state_reg.statusWord <= `CSCR_RESET_BYTE;
            state_reg.powerControl <= `CSCR_RESET_BYTE;
            state_reg.chipConfig <= `CSCR_RESET_BYTE; // [R15]
            state_reg.readData <= `CSCR_RESET_BYTE;
            state_reg.readHit <= 1'b0;
            state_reg.routeInternal <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // all straight from flip-flops, upper stack bits hidden when off
    assign sfrReadData = state_reg.readData;
    assign sfrReadHit = state_reg.readHit;
    assign dataPointer = {state_reg.dpPage, state_reg.dpHigh, state_reg.dpLow}; // [R01]
    assign xdataOnChip = state_reg.routeInternal; // [R18] [R19] [R20]
    assign stackAddress = {extStackOn ? state_reg.stackUpper : 3'h0,
                           state_reg.stackLow}; // [R05] [R17]
    assign bankSelect = {state_reg.statusWord[`CSCR_SW_BANK_HIGH],
                         state_reg.statusWord[`CSCR_SW_BANK_LOW]}; // [R08]
    assign baudDoubler = state_reg.powerControl[`CSCR_PWR_BAUD_DOUBLER]; // [R09]
    assign latchStrobeEnable = ~state_reg.powerControl[`CSCR_PWR_LATCH_OFF]; // [R12]
    assign powerDownActive = state_reg.powerControl[`CSCR_PWR_POWER_DOWN]; // [R14]

endmodule : cscr_core_regs

//--- logic/cscr_pkg.sv
/*
 * Holds the state types of the core status and configuration register bank.
 * Assumes the constants header is available to the files that use it.
 */
package cscr_pkg;

    // ************************************************************
    // state of the register bank
    // ************************************************************
    typedef struct packed {
        logic [7:0] dpPage;
        logic [7:0] dpHigh;
        logic [7:0] dpLow;
        logic [7:0] stackLow;
        logic [2:0] stackUpper;
        logic [7:0] statusWord;
        logic [7:0] powerControl;
        logic [7:0] chipConfig;
        logic [7:0] readData;
        logic readHit;
        logic routeInternal;
    } cscr_bank_state_t;

    // ************************************************************
    // state of the wake pin detector
    // ************************************************************
    typedef struct packed {
        logic syncFirst;
        logic syncSecond;
        logic pinPrevious;
    } cscr_wake_state_t;

endpackage : cscr_pkg

//--- logic/cscr_wake_detect.sv
/*
 * Synchronises the external interrupt zero pin and turns it into a wake
 * condition: low level or falling edge, chosen by the trigger type.
 * Assumes the pin is asynchronous to clk and the trigger type is on clk.
 */
`timescale 1ns/1ps

module cscr_wake_detect (
    input wire logic clk,
    input wire logic reset,
    input wire logic pinIn,
    input wire logic triggerEdge,
    output logic wakeCondition
);

    cscr_pkg::cscr_wake_state_t state_reg;
    cscr_pkg::cscr_wake_state_t state_next;

    // ************************************************************
    // synchroniser and edge memory
    // ************************************************************

    // first stage feeds only the second stage
    always_comb begin
        state_next = state_reg;
        state_next.syncFirst = pinIn;
        state_next.syncSecond = state_reg.syncFirst;
        state_next.pinPrevious = state_reg.syncSecond;
    end

    // pin idles high, so reset to high avoids a false edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '{syncFirst: 1'b1, syncSecond: 1'b1, pinPrevious: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    // level low, or high-to-low step, on the synchronised pin
    assign wakeCondition = triggerEdge ? (state_reg.pinPrevious & ~state_reg.syncSecond)
                                       : ~state_reg.syncSecond;

endmodule : cscr_wake_detect

//--- testbench/cscr_core_regs_asserts.sv
/*
 * Port-level checker for the core register bank.
 * Assumes binding to cscr_core_regs; sees its ports only.
 */
`timescale 1ns/1ps

module cscr_core_regs_asserts (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWriteData,
    input wire logic [7:0] sfrReadData,
    input wire logic sfrReadHit,
    input wire logic dptrIncrement,
    input wire logic dptrLoad16,
    input wire logic [15:0] dptrLoadValue,
    input wire logic [23:0] dataPointer,
    input wire logic xdataOnChip,
    input wire logic stackPush,
    input wire logic stackPop,
    input wire logic [10:0] stackAddress,
    input wire logic [7:0] accumulator,
    input wire logic [1:0] bankSelect,
    input wire logic baudDoubler,
    input wire logic latchStrobeEnable,
    input wire logic spiIrq,
    input wire logic i2cIrq,
    input wire logic extIrq0Pin,
    input wire logic powerDownActive
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ************************************************************
    // sequences
    // ************************************************************
    // parity lags by one edge: skip reads just after reset
    sequence statusRead;
        sfrRead && sfrAddr == 8'hd0 && !$past(reset);
    endsequence
    // pin high long enough that no pin wake is pending
    sequence pinQuiet;
        extIrq0Pin && $past(extIrq0Pin) && $past(extIrq0Pin, 2) && $past(extIrq0Pin, 3);
    endsequence
    sequence powerDownWrite;
        sfrWrite && sfrAddr == 8'h87 && sfrWriteData[1] && !spiIrq && !i2cIrq;
    endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    a_push_step: assert property (stackPush && !stackPop |=>
        stackAddress[7:0] == $past(stackAddress[7:0]) + 8'h01)
        else $error("push step wrong");
    a_pop_step: assert property (stackPop && !stackPush |=>
        stackAddress[7:0] == $past(stackAddress[7:0]) - 8'h01)
        else $error("pop step wrong");
    a_data_pointer_step: assert property (dptrIncrement && !dptrLoad16 |=>
        dataPointer == $past(dataPointer) + 24'h00_0001)
        else $error("pointer increment wrong");
    a_data_pointer_load: assert property (dptrLoad16 && !(sfrWrite && sfrAddr == 8'h84) |=>
        dataPointer == {$past(dataPointer[23:16]), $past(dptrLoadValue)})
        else $error("pointer load wrong");
    a_xdata_range: assert property (xdataOnChip |-> dataPointer <= 24'h00_07ff)
        else $error("on-chip xdata out of range");
    a_power_bits: assert property (sfrWrite && sfrAddr == 8'h87 |=>
        baudDoubler == $past(sfrWriteData[7]) && latchStrobeEnable == !$past(sfrWriteData[4]))
        else $error("power outputs wrong");
    a_bank_write: assert property (sfrWrite && sfrAddr == 8'hd0 |=>
        bankSelect == $past(sfrWriteData[4:3]))
        else $error("bank select wrong");
    a_parity_read: assert property (statusRead |=>
        sfrReadData[0] == ^$past(accumulator, 2))
        else $error("parity wrong");
    a_power_down: assert property (powerDownWrite ##0 pinQuiet |=> powerDownActive)
        else $error("no power-down");
    a_stack_read: assert property (sfrRead && sfrAddr == 8'h81 |=>
        sfrReadHit && sfrReadData == $past(stackAddress[7:0]))
        else $error("stack read wrong");
endmodule : cscr_core_regs_asserts

bind cscr_core_regs cscr_core_regs_asserts u_asserts (.clk(clk), .reset(reset),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWriteData(sfrWriteData),
    .sfrReadData(sfrReadData), .sfrReadHit(sfrReadHit), .dptrIncrement(dptrIncrement),
    .dptrLoad16(dptrLoad16), .dptrLoadValue(dptrLoadValue), .dataPointer(dataPointer),
    .xdataOnChip(xdataOnChip), .stackPush(stackPush), .stackPop(stackPop),
    .stackAddress(stackAddress), .accumulator(accumulator), .bankSelect(bankSelect),
    .baudDoubler(baudDoubler), .latchStrobeEnable(latchStrobeEnable), .spiIrq(spiIrq),
    .i2cIrq(i2cIrq), .extIrq0Pin(extIrq0Pin), .powerDownActive(powerDownActive));

//--- testbench/cscr_core_regs_test.sv
/*
 * Self-checking bench for the core status and configuration register bank.
 * Assumes the design and its checker are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module cscr_core_regs_test;
    logic clk = 1'b0;
    logic reset, sfrWrite, sfrRead, dptrIncrement, dptrLoad16, stackPush, stackPop;
    logic flagUpdate, carryIn, halfCarryIn, rangeIn, spiIrq, i2cIrq;
    logic extIrq0Pin, extIrq0TriggerType, sfrReadHit, xdataOnChip;
    logic baudDoubler, latchStrobeEnable, powerDownActive;
    logic [7:0] sfrAddr, sfrWriteData, accumulator, sfrReadData;
    logic [15:0] dptrLoadValue;
    logic [23:0] dataPointer;
    logic [10:0] stackAddress;
    logic [1:0] bankSelect;
    int checks = 0;
    int n_mismatch = 0;

    cscr_core_regs uut (.clk(clk), .reset(reset), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrRead(sfrRead), .sfrWriteData(sfrWriteData), .sfrReadData(sfrReadData),
        .sfrReadHit(sfrReadHit), .dptrIncrement(dptrIncrement), .dptrLoad16(dptrLoad16),
        .dptrLoadValue(dptrLoadValue), .dataPointer(dataPointer), .xdataOnChip(xdataOnChip),
        .stackPush(stackPush), .stackPop(stackPop), .stackAddress(stackAddress),
        .flagUpdate(flagUpdate), .carryIn(carryIn), .halfCarryIn(halfCarryIn),
        .rangeIn(rangeIn), .accumulator(accumulator), .bankSelect(bankSelect),
        .baudDoubler(baudDoubler), .latchStrobeEnable(latchStrobeEnable), .spiIrq(spiIrq),
        .i2cIrq(i2cIrq), .extIrq0Pin(extIrq0Pin), .extIrq0TriggerType(extIrq0TriggerType),
        .powerDownActive(powerDownActive));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // ************************************************************
    // bus and strobe tasks, all entered at a falling edge
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfrAddr = a;
        sfrWriteData = d;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask : wr

    // answer stands one cycle: judged at the next falling edge
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic hit);
        @(negedge clk);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        `CHK("sfrReadData", ex, sfrReadData)
        `CHK("sfrReadHit", hit, sfrReadHit)
    endtask : rd

    // bits: load16, push, pop, increment
    task automatic strobe(input logic [3:0] s);
        @(negedge clk);
        {dptrLoad16, stackPush, stackPop, dptrIncrement} = s;
        @(negedge clk);
        {dptrLoad16, stackPush, stackPop, dptrIncrement} = 4'h0;
    endtask : strobe

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        `CHK("stackAddress", 11'h007, stackAddress)
        `CHK("latchStrobeEnable", 1'b1, latchStrobeEnable)
        rd(8'h87, 8'h00, 1'b1);
        rd(8'haf, 8'h00, 1'b1);
        rd(8'hb7, 8'h00, 1'b0);
        rd(8'h80, 8'h00, 1'b0);
        strobe(4'b0100);
        `CHK("stackAddress", 11'h008, stackAddress)
    endtask : t_reset

    task automatic t_stack;
        wr(8'h81, 8'hff);
        strobe(4'b0100);
        `CHK("stackAddress", 11'h000, stackAddress)
        rd(8'h81, 8'h00, 1'b1);
        wr(8'hb7, 8'h05);
        wr(8'haf, 8'hff);
        rd(8'haf, 8'h81, 1'b1);
        rd(8'hb7, 8'h00, 1'b1);
        wr(8'h81, 8'hff);
        strobe(4'b0100);
        `CHK("stackAddress", 11'h100, stackAddress)
        rd(8'hb7, 8'h01, 1'b1);
        strobe(4'b0010);
        `CHK("stackAddress", 11'h0ff, stackAddress)
        wr(8'hb7, 8'hff);
        rd(8'hb7, 8'h07, 1'b1);
        wr(8'haf, 8'h00);
        `CHK("stackAddress", 11'h0ff, stackAddress)
    endtask : t_stack

    task automatic t_data_pointer;
        wr(8'haf, 8'h01);
        dptrLoadValue = 16'h07fe;
        strobe(4'b1000);
        strobe(4'b0001);
        `CHK("dataPointer", 24'h00_07ff, dataPointer)
        `CHK("xdataOnChip", 1'b1, xdataOnChip)
        strobe(4'b0001);
        `CHK("xdataOnChip", 1'b0, xdataOnChip)
        wr(8'h83, 8'hff);
        wr(8'h82, 8'hff);
        wr(8'h84, 8'h12);
        strobe(4'b0001);
        `CHK("dataPointer", 24'h13_0000, dataPointer)
        rd(8'h84, 8'h13, 1'b1);
        wr(8'h84, 8'h00);
        `CHK("xdataOnChip", 1'b1, xdataOnChip)
        wr(8'haf, 8'h00);
        `CHK("xdataOnChip", 1'b0, xdataOnChip)
    endtask : t_data_pointer

    task automatic t_status;
        for (int b = 0; b < 4; b++) begin
            wr(8'hd0, 8'(b << 3));
            `CHK("bankSelect", 2'(b), bankSelect)
        end
        wr(8'hd0, 8'hff);
        rd(8'hd0, 8'hfe, 1'b1);
        {flagUpdate, carryIn, halfCarryIn, rangeIn} = 4'b1010;
        accumulator = 8'h07;
        @(negedge clk);
        flagUpdate = 1'b0;
        rd(8'hd0, 8'h7b, 1'b1);
    endtask : t_status

    task automatic t_power;
        wr(8'h87, 8'h9d);
        `CHK("baudDoubler", 1'b1, baudDoubler)
        `CHK("latchStrobeEnable", 1'b0, latchStrobeEnable)
        rd(8'h87, 8'h9c, 1'b1);
        // serial wake needs its enable
        for (int i = 0; i < 4; i++) begin
            wr(8'h87, i[1] ? 8'h42 : 8'h02);
            `CHK("powerDownActive", 1'b1, powerDownActive)
            {spiIrq, i2cIrq} = i[0] ? 2'b01 : 2'b10;
            @(negedge clk);
            {spiIrq, i2cIrq} = 2'b00;
            `CHK("powerDownActive", !i[1], powerDownActive)
        end
        wr(8'h87, 8'h22);
        extIrq0Pin = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("powerDownActive", 1'b0, powerDownActive)
        // edge mode: a pin held low does not wake
        extIrq0TriggerType = 1'b1;
        repeat (3) @(negedge clk);
        wr(8'h87, 8'h22);
        repeat (3) @(negedge clk);
        `CHK("powerDownActive", 1'b1, powerDownActive)
        extIrq0Pin = 1'b1;
        repeat (4) @(negedge clk);
        extIrq0Pin = 1'b0;
        repeat (4) @(negedge clk);
        `CHK("powerDownActive", 1'b0, powerDownActive)
    endtask : t_power

    // ************************************************************
    // verdict, main sequence and watchdog
    // ************************************************************
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    initial begin
        reset = 1'b1;
        {sfrWrite, sfrRead, dptrIncrement, dptrLoad16, stackPush, stackPop} = 6'h00;
        {flagUpdate, carryIn, halfCarryIn, rangeIn, spiIrq, i2cIrq} = 6'h00;
        {extIrq0Pin, extIrq0TriggerType} = 2'b10;
        {sfrAddr, sfrWriteData, accumulator, dptrLoadValue} = 40'h0;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        t_reset;
        t_stack;
        t_data_pointer;
        t_status;
        t_power;
        end_sim;
    end

    // run takes about 120 cycles
    initial begin
        #125000;
        n_mismatch++;
        end_sim;
    end
endmodule : cscr_core_regs_test
